// [inc/sam_map.vh]
`ifndef SAM_MAP_VH
`define SAM_MAP_VH
// ----------------------------------------
// register word addresses
// ----------------------------------------
`define SAM_ADDR_MUTE      16'hf580
`define SAM_ADDR_RATIO     16'hf582
`define SAM_ADDR_RAMP_OVR  16'hf590
`define SAM_ADDR_RAMP_CH   16'hf591
`define SAM_ADDR_ADC       16'hf5a0
`define SAM_ADDR_ALT_PIN   16'hf5f0
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SAM_OVR_EN_BIT     11
`define SAM_RAMP_MSB       10
`define SAM_MUTE_DIS0_BIT  8
`define SAM_MUTE_DIS1_BIT  9
`define SAM_RST_RAMP       11'h7ff
`define SAM_RST_ZERO       16'h0000
`define SAM_ADC_MSB        9
`define SAM_RST_ADC        10'h000
`define SAM_ALT_EN_BIT     0
`define SAM_WORD_BITS      16
`endif

// [verilog/sam_regs.v]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sam_map.vh"

module sam_regs #(
  parameter NUM_CONV = 8,
  parameter NUM_ADC  = 6
) (
  input  wire                     clk,
  input  wire                     resetn,
  input  wire [15:0]              reg_addr,
  input  wire [15:0]              reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [15:0]              reg_rdata,
  input  wire [NUM_CONV*16-1:0]   ratio_in,
  input  wire                     ratio_valid,
  input  wire                     frame_tick,
  input  wire [NUM_ADC*10-1:0]    adc_in,
  output wire [NUM_CONV-1:0]      conv_mute,
  output wire [NUM_CONV*11-1:0]   ramp_limit,
  input  wire                     mst_scl_out,
  input  wire                     mst_scl_oe,
  input  wire                     mst_sda_out,
  input  wire                     mst_sda_oe,
  output wire                     default_pin_a_out,
  output wire                     default_pin_a_oe,
  output wire                     default_pin_b_out,
  output wire                     default_pin_b_oe,
  output wire                     alt_pin_a_out,
  output wire                     alt_pin_a_oe,
  output wire                     alt_pin_b_out,
  output wire                     alt_pin_b_oe
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // word map seen from the control port:
  //   mute control         one word, manual mutes and block disables
  //   rate ratios          NUM_CONV words, loaded from the converter side only
  //   ramp override        one word, enable and global value
  //   channel ramp limits  NUM_CONV words, software side
  //   aux adc results      NUM_ADC words, refreshed on the frame tick
  //   master pin route     one word, bit 0 only
  //   anything else reads zero and ignores writes

  reg  [NUM_CONV-1:0] manual_mute_reg;
  reg  [1:0]          mute_disable_reg;
  reg                 override_en_reg;
  reg  [10:0]         override_ramp_limit_reg;
  reg                 alt_pin_route_enable_reg;
  wire [NUM_CONV-1:0] conv_block_disable;
  // per-channel words sit in holding registers further down
  wire [15:0]         ratio_reg [0:NUM_CONV-1];
  wire [10:0]         channel_ramp_limit_reg [0:NUM_CONV-1];
  wire [9:0]          adc_reg [0:NUM_ADC-1];
  // write and read hits, one per word
  wire                wr_mute_hit;
  wire                wr_ovr_hit;
  wire                wr_alt_pin_hit;
  wire [NUM_CONV-1:0] wr_ramp_ch_hit;
  wire                rd_mute_hit;
  wire                rd_ovr_hit;
  wire                rd_alt_pin_hit;
  wire [NUM_CONV-1:0] rd_ratio_hit;
  wire [NUM_CONV-1:0] rd_ramp_ch_hit;
  wire [NUM_ADC-1:0]  rd_adc_hit;
  // fixed-layout words as seen on a read
  wire [15:0]         mute_rd_word;
  wire [15:0]         ovr_rd_word;
  wire [15:0]         alt_pin_rd_word;
  reg  [15:0]         rdata_next;
  // loop index, used by the read multiplexer only
  integer             i;

  // ----------------------------------------
  // mute and ramp-limit outputs
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g = g + 1) begin : g_conv
      // each group of four converters shares one disable bit
      assign conv_block_disable[g] = mute_disable_reg[g/4];
      // disable bit wins: the block never mutes at all
      assign conv_mute[g] = manual_mute_reg[g] & ~conv_block_disable[g];
      // override replaces every channel limit while enabled
      assign ramp_limit[g*11 +: 11] = override_en_reg ? override_ramp_limit_reg
                                                      : channel_ramp_limit_reg[g];
    end
  endgenerate

  // ----------------------------------------
  // master pin routing
  // ----------------------------------------
  // pin routing; the unselected pair is released (enable low)
  assign default_pin_a_out = mst_scl_out;
  assign default_pin_b_out = mst_sda_out;
  assign alt_pin_a_out     = mst_scl_out;
  assign alt_pin_b_out     = mst_sda_out;
  assign default_pin_a_oe  = mst_scl_oe & ~alt_pin_route_enable_reg;
  assign default_pin_b_oe  = mst_sda_oe & ~alt_pin_route_enable_reg;
  assign alt_pin_a_oe      = mst_scl_oe & alt_pin_route_enable_reg;
  assign alt_pin_b_oe      = mst_sda_oe & alt_pin_route_enable_reg;

  // ----------------------------------------
  // software writes and hardware updates
  // ----------------------------------------
  // write hits decoded once, so each register process stays small
  assign wr_mute_hit    = reg_wr & (reg_addr == `SAM_ADDR_MUTE);
  assign wr_ovr_hit     = reg_wr & (reg_addr == `SAM_ADDR_RAMP_OVR);
  assign wr_alt_pin_hit = reg_wr & (reg_addr == `SAM_ADDR_ALT_PIN);

  // ----------------------------------------
  // mute control
  // ----------------------------------------
  // manual mutes and the two block disables share one word
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      manual_mute_reg  <= {NUM_CONV{1'b0}};
      mute_disable_reg <= 2'b00;
    end else if (wr_mute_hit) begin
      manual_mute_reg  <= reg_wdata[NUM_CONV-1:0];
      mute_disable_reg <= {reg_wdata[`SAM_MUTE_DIS1_BIT], reg_wdata[`SAM_MUTE_DIS0_BIT]};
    end
  end

  // ----------------------------------------
  // ramp-limit override
  // ----------------------------------------
  // enable resets off while the value resets to its maximum
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      override_en_reg         <= 1'b0;
      override_ramp_limit_reg <= `SAM_RST_RAMP;
    end else if (wr_ovr_hit) begin
      override_en_reg         <= reg_wdata[`SAM_OVR_EN_BIT];
      override_ramp_limit_reg <= reg_wdata[`SAM_RAMP_MSB:0];
    end
  end

  // ----------------------------------------
  // master pin route bit
  // ----------------------------------------
  // reserved bits are never stored, so they always read zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      alt_pin_route_enable_reg <= 1'b0;
    else if (wr_alt_pin_hit)
      alt_pin_route_enable_reg <= reg_wdata[`SAM_ALT_EN_BIT];
  end

  // ----------------------------------------
  // per-channel holding registers
  // ----------------------------------------
  // channel limits load from software; status words load from hardware only, so software writes bounce off
  generate
    for (g = 0; g < NUM_CONV; g = g + 1) begin : g_conv_store
      // channel ramp-limit word write hit
      assign wr_ramp_ch_hit[g] = reg_wr & (reg_addr == `SAM_ADDR_RAMP_CH + g);

      // channel ramp limit, written by software
      sam_load_reg #(
        .WIDTH       (`SAM_RAMP_MSB + 1),
        .RESET_VALUE (`SAM_RST_RAMP)
      ) i_ramp_ch (
        .clk       (clk),
        .resetn    (resetn),
        .load      (wr_ramp_ch_hit[g]),
        .d         (reg_wdata[`SAM_RAMP_MSB:0]),
        .value_reg (channel_ramp_limit_reg[g])
      );

      // rate ratio, loaded from the converter side only
      sam_load_reg #(
        .WIDTH       (`SAM_WORD_BITS),
        .RESET_VALUE (`SAM_RST_ZERO)
      ) i_ratio (
        .clk       (clk),
        .resetn    (resetn),
        .load      (ratio_valid),
        .d         (ratio_in[g*16 +: 16]),
        .value_reg (ratio_reg[g])
      );
    end

    for (g = 0; g < NUM_ADC; g = g + 1) begin : g_adc_store
      // one refresh per frame tick, codes passed unscaled
      sam_load_reg #(
        .WIDTH       (`SAM_ADC_MSB + 1),
        .RESET_VALUE (`SAM_RST_ADC)
      ) i_adc (
        .clk       (clk),
        .resetn    (resetn),
        .load      (frame_tick),
        .d         (adc_in[g*10 +: 10]),
        .value_reg (adc_reg[g])
      );
    end

  endgenerate

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // read hits on the address alone; the strobe gates the output register
  assign rd_mute_hit    = (reg_addr == `SAM_ADDR_MUTE);
  assign rd_ovr_hit     = (reg_addr == `SAM_ADDR_RAMP_OVR);
  assign rd_alt_pin_hit = (reg_addr == `SAM_ADDR_ALT_PIN);
  generate
    // ratio and channel limit words, one hit each
    for (g = 0; g < NUM_CONV; g = g + 1) begin : g_conv_rd
      assign rd_ratio_hit[g]   = (reg_addr == `SAM_ADDR_RATIO + g);
      assign rd_ramp_ch_hit[g] = (reg_addr == `SAM_ADDR_RAMP_CH + g);
    end
    // adc result words
    for (g = 0; g < NUM_ADC; g = g + 1) begin : g_adc_rd
      assign rd_adc_hit[g] = (reg_addr == `SAM_ADDR_ADC + g);
    end
  endgenerate

  // ----------------------------------------
  // read word assembly
  // ----------------------------------------
  // fixed words padded to sixteen bits; unused bits read zero
  assign mute_rd_word    = {6'h00, mute_disable_reg, manual_mute_reg};
  assign ovr_rd_word     = {4'h0, override_en_reg, override_ramp_limit_reg};
  assign alt_pin_rd_word = {15'h0000, alt_pin_route_enable_reg};

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  // hits are disjoint; unmapped addresses fall through to zero
  always @* begin
    rdata_next = `SAM_RST_ZERO;
    if (rd_mute_hit)
      rdata_next = mute_rd_word;
    if (rd_ovr_hit)
      rdata_next = ovr_rd_word;
    if (rd_alt_pin_hit)
      rdata_next = alt_pin_rd_word;
    for (i = 0; i < NUM_CONV; i = i + 1) begin
      if (rd_ratio_hit[i])
        rdata_next = ratio_reg[i];
      if (rd_ramp_ch_hit[i])
        rdata_next = {5'h00, channel_ramp_limit_reg[i]};
    end
    for (i = 0; i < NUM_ADC; i = i + 1) begin
      if (rd_adc_hit[i])
        rdata_next = {6'h00, adc_reg[i]};
    end
  end

  // read data registered, valid only the cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `SAM_RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `SAM_RST_ZERO;
    end
  end

endmodule // sam_regs

// ----------------------------------------
// loadable holding register
// ----------------------------------------
// one word that loads on a strobe and otherwise keeps its value
module sam_load_reg #(
  parameter             WIDTH       = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             load,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] value_reg
);

  // reset takes only the constant parameter, never a signal
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value_reg <= RESET_VALUE;
    end else if (load) begin
      value_reg <= d;
    end
  end

endmodule // sam_load_reg
`default_nettype wire

// [verification/sam_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module sam_regs_checker #(parameter NUM_CONV = 8) (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [15:0]            reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  input wire logic [NUM_CONV*11-1:0] ramp_limit,
  input wire logic                   mst_scl_oe,
  input wire logic                   default_pin_a_oe,
  input wire logic                   alt_pin_a_oe
);
  // ---------------------------------
  // register port and pin routing
  // ---------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // read strobe inside an address range
  sequence s_rd(lo, hi); reg_rd && reg_addr >= lo && reg_addr <= hi; endsequence
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  chk_pin_rsvd: assert property (s_rd(16'hf5f0, 16'hf5f0) |=> reg_rdata[15:1] == 15'h0)
    else $error("route reserved bits set");
  chk_adc_upper: assert property (s_rd(16'hf5a0, 16'hf5a5) |=> reg_rdata[15:10] == 6'h0)
    else $error("adc upper bits set");
  chk_ovr_rsvd: assert property (s_rd(16'hf590, 16'hf590) |=> reg_rdata[15:12] == 4'h0)
    else $error("override reserved bits set");
  chk_chan_rsvd: assert property (s_rd(16'hf591, 16'hf598) |=> reg_rdata[15:11] == 5'h0)
    else $error("channel limit upper bits set");
  chk_route_excl: assert property (!(alt_pin_a_oe && default_pin_a_oe))
    else $error("both pin pairs enabled");
  chk_route_follow: assert property ((alt_pin_a_oe | default_pin_a_oe) == mst_scl_oe)
    else $error("clock enable not routed");
  chk_ramp_hold: assert property (!reg_wr |=> $stable(ramp_limit))
    else $error("ramp limit moved without write");
endmodule // sam_regs_checker
bind sam_regs sam_regs_checker #(.NUM_CONV(NUM_CONV)) chk (.*);
`default_nettype wire

// [verification/sam_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sam_regs_test;
  logic         clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, ratio_valid = 0, frame_tick = 0;
  logic [15:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [127:0] ratio_in = 0;
  logic [59:0]  adc_in = 0;
  logic [7:0]   conv_mute, pins;
  logic [87:0]  ramp_limit;
  logic [3:0]   mst = 0;
  int           errors = 0, comparisons = 0;
  // ---------------------------------
  // clock, device and shared tasks
  // ---------------------------------
  always #20 clk = ~clk;
  sam_regs i_sam_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ratio_in(ratio_in),
    .ratio_valid(ratio_valid), .frame_tick(frame_tick), .adc_in(adc_in), .conv_mute(conv_mute),
    .ramp_limit(ramp_limit), .mst_scl_out(mst[0]), .mst_scl_oe(mst[1]), .mst_sda_out(mst[2]),
    .mst_sda_oe(mst[3]), .default_pin_a_out(pins[0]), .default_pin_a_oe(pins[1]),
    .default_pin_b_out(pins[2]), .default_pin_b_oe(pins[3]), .alt_pin_a_out(pins[4]),
    .alt_pin_a_oe(pins[5]), .alt_pin_b_out(pins[6]), .alt_pin_b_oe(pins[7]));
  task cmp(input logic [87:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; effects land at the edge ending the strobe
  task wr(input logic [15:0] a, d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 0;
  endtask
  task rd(input logic [15:0] a, e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 0;
    #1 cmp(reg_rdata, e);
  endtask
  task t_reset;
    for (logic [15:0] i = 0; i < 8; i++) rd(16'hf582 + i, 16'h0000);
    for (logic [15:0] i = 0; i < 8; i++) rd(16'hf591 + i, 16'h07ff);
    for (logic [15:0] i = 0; i < 6; i++) rd(16'hf5a0 + i, 16'h0000);
    rd(16'hf590, 16'h07ff);
    rd(16'hf5f0, 16'h0000);
    rd(16'hf5ff, 16'h0000);
    cmp(ramp_limit, {8{11'h7ff}});
  endtask
  // upper bits written set must not reach the 11-bit field
  task t_ramp;
    logic [87:0] e;
    for (int i = 0; i < 8; i++) wr(16'hf591 + 16'(i), 16'hf800 | 16'(i));
    for (int i = 0; i < 8; i++) e[11*i +: 11] = 11'(i);
    #1 cmp(ramp_limit, e);
    wr(16'hf590, 16'h0923);
    #1 cmp(ramp_limit, {8{11'h123}});
    wr(16'hf590, 16'h0123);
    #1 cmp(ramp_limit, e);
  endtask
  task t_mute;
    wr(16'hf580, 16'h00a5);
    #1 cmp(conv_mute, 8'ha5);
    wr(16'hf580, 16'h01ff);
    #1 cmp(conv_mute, 8'hf0);
    wr(16'hf580, 16'h02ff);
    #1 cmp(conv_mute, 8'h0f);
    rd(16'hf580, 16'h02ff);
  endtask
  // status fields load from hardware only; software writes bounce off
  task t_status;
    logic [15:0] v [6] = '{16'h03ff, 16'h0100, 16'h0200, 16'h0000, 16'h0001, 16'h03ff};
    @(posedge clk) {ratio_valid, frame_tick} <= 2'b11;
    for (int i = 0; i < 8; i++) ratio_in[16*i +: 16] <= 16'h1000 + 16'(i);
    for (int i = 0; i < 6; i++) adc_in[10*i +: 10] <= v[i][9:0];
    @(posedge clk) {ratio_valid, frame_tick, adc_in} <= {2'b00, {6{10'h155}}};
    wr(16'hf582, 16'hbeef);
    wr(16'hf5a0, 16'h0055);
    for (logic [15:0] i = 0; i < 8; i++) rd(16'hf582 + i, 16'h1000 + i);
    for (int i = 0; i < 6; i++) rd(16'hf5a0 + 16'(i), v[i]);
    @(posedge clk) frame_tick <= 1;
    @(posedge clk) frame_tick <= 0;
    rd(16'hf5a3, 16'h0155);
  endtask
  task t_route;
    @(posedge clk) mst <= 4'b1011; // only the two-wire engine drives
    #1 cmp({pins[7], pins[5], pins[3:0]}, 6'b001011);
    wr(16'hf5f0, 16'hffff);
    rd(16'hf5f0, 16'h0001);
    cmp({pins[3], pins[1], pins[7:4]}, 6'b001011);
  endtask
  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    t_reset;
    t_ramp;
    t_mute;
    t_status;
    t_route;
    end_of_test;
  end
endmodule // sam_regs_test
`default_nettype wire
